// ---- include/swr_pkg.sv ----
// Shared constants and types of the sleep, wake and counter block
package swr_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_WAKE_CTRL  = 8'h00;
	localparam logic [7:0] ADR_SLEEP_CTRL = 8'h04;
	localparam logic [7:0] ADR_STATUS     = 8'h08;
	localparam logic [7:0] ADR_PERIOD     = 8'h0C;
	localparam logic [7:0] ADR_COUNT      = 8'h10;
	localparam logic [7:0] ADR_STEAL      = 8'h14;
	localparam logic [7:0] ADR_TRIM       = 8'h18;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int EXT_N        = 4;
	localparam int OFF_W        = 6;
	localparam int TRIM_W       = 5;
	localparam int WC_TIMER_EN  = 0;
	localparam int WC_CNT_EN    = 1;
	localparam int WC_AUTO_ADC  = 3;
	localparam int WC_EXT_EN    = 8;
	localparam int WC_EXT_EDGE  = 12;
	localparam int WC_CNT_IEN   = 16;
	localparam int WC_EXT_IEN   = 20;
	localparam int SC_HIBER     = 0;
	localparam int SC_DOZE      = 1;
	localparam int SC_RETAIN    = 2;
	localparam int SC_XTAL_SEL  = 3;
	localparam int ST_SYNC      = 0;
	localparam int ST_HIBER_WK  = 1;
	localparam int ST_DOZE_WAKE = 2;
	localparam int ST_CNT       = 3;
	localparam int ST_EXT       = 4;
	localparam int BS_MODEM     = 0;
	localparam int BS_MANUAL    = 1;
	localparam int BS_UNTIL_IRQ = 2;
	localparam int BS_OFF       = 8;
	localparam int TR_COARSE    = 0;
	localparam int TR_FINE      = 8;

	// ------------------------------------------------------------
	// Writable bit masks and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] WC_MASK    = 32'h00F1_FF0B;
	localparam logic [31:0] SC_MASK    = 32'h0000_000F;
	localparam logic [31:0] BS_MASK    = 32'h0000_3F07;
	localparam logic [31:0] TR_MASK    = 32'h0000_1F1F;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [31:0] RST_PERIOD = 32'h0000_0000;
	localparam logic [31:0] RST_TRIM   = 32'h0000_0000;
	localparam logic [7:0]  RST_STATUS = 8'h00;

	// Power sequencing states
	typedef enum logic [2:0] {
		PWR_RUN,
		PWR_PRE_SLEEP,
		PWR_SLEEP,
		PWR_ADC,
		PWR_WAKE_SYNC
	} swr_pwr_t;

endpackage : swr_pkg

// ---- hw/swr_sync3.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module swr_sync3 (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic asyncIn,
	output logic      syncOut
);

	typedef struct packed {
		logic [2:0] chain;
		logic       level;
	} swr_sync_st_t;

	swr_sync_st_t s_ff;
	swr_sync_st_t nxt_s;

	// ------------------------------------------------------------
	// Shift and filter
	// ------------------------------------------------------------
	// Stage 0 feeds only stage 1; level follows once stages 1 and 2 agree
	always_comb begin
		nxt_s = s_ff;
		nxt_s.chain = {s_ff.chain[1:0], asyncIn};
		if (s_ff.chain[1] == s_ff.chain[2]) begin
			nxt_s.level = s_ff.chain[2];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign syncOut = s_ff.level;

	sync_agree_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_ff.chain[1] != s_ff.chain[2]) |=> $stable(s_ff.level))
		else $error("sync level moved without agreement");

endmodule : swr_sync3

// ---- hw/swr_steal_duty.sv ----
// Bus steal duty cycle generator with DMA priority
`timescale 1ns/100ps
module swr_steal_duty (
	input  wire logic                    sys_clk,
	input  wire logic                    reset_n,
	input  wire logic                    stealReq,
	input  wire logic                    dmaReq,
	input  wire logic [swr_pkg::OFF_W-1:0] offTime,
	output logic                         stealActive
);

	typedef struct packed {
		logic [swr_pkg::OFF_W-1:0] phase;
	} swr_duty_st_t;

	swr_duty_st_t s_ff;
	swr_duty_st_t nxt_s;
	logic         offPhase;

	// ------------------------------------------------------------
	// Duty counter
	// ------------------------------------------------------------
	// Steal offTime cycles, then hand the CPU one cycle; a zero off-time never steals
	always_comb begin
		nxt_s = s_ff;
		offPhase = s_ff.phase < offTime;
		if (!stealReq) begin
			nxt_s.phase = '0;
		end else if (offPhase) begin
			nxt_s.phase = s_ff.phase + 6'h01;
		end else begin
			nxt_s.phase = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// DMA always wins the bus at once
	assign stealActive = stealReq && offPhase && !dmaReq;

	dma_yield_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		dmaReq |-> !stealActive)
		else $error("steal held bus against DMA");

	duty_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(stealReq && $stable(offTime) && s_ff.phase == offTime) |=> s_ff.phase == 6'h00)
		else $error("steal duty phase did not wrap");

endmodule : swr_steal_duty

// ---- hw/swr_sleep_wake.sv ----
// Sleep, wake, real-time counter and bus steal control core
// Operation
// - 32-bit counter runs on selected slow clock
// - Time-outs only while wake control bit 1
// - Time-out interrupt only while bit 16 set
// - Time-out sets status bit 3
// - Timer or counter wake sets matching flag
// - Next point is count plus period
// - Count register reads whole in one access
// - Four wake inputs, level or edge, interrupt
// - Entry sets sync flag, waits software clear
// - Exit sets sync flag, waits software clear
// - Auto ADC only while wake bit 3
// - Hibernate counter wake halts CPU, timer wakes normally
// - Halted wake: oscillator, steal, one conversion
// - ADC done quietly: back to hibernate
// - ADC interrupt releases steal, CPU runs
// - Trims reset zero, kept across hibernate
// - Modem steal only during modem activity
// - Manual steal continues until cleared
// - Wait mode steals until interrupt request
// - Duty from off-time, DMA always first
`timescale 1ns/100ps
module swr_sleep_wake (
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [7:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        ringOscIn,
	input  wire logic                        xtalOscIn,
	input  wire logic [swr_pkg::EXT_N-1:0]   externalWakeInputs,
	input  wire logic                        wakeTimerExpire,
	input  wire logic                        modemActive,
	input  wire logic                        dmaReq,
	input  wire logic                        anyIrqReq,
	input  wire logic                        adcDone,
	input  wire logic                        adcIrq,
	output logic                             counterIrqReq,
	output logic                             extIrqReq,
	output logic                             sleepPowerDown,
	output logic                             refOscEnable,
	output logic                             adcStart,
	output logic                             busStealActive,
	output logic                             cpuHalt,
	output logic                             processorRetention,
	output logic [swr_pkg::TRIM_W-1:0]       crystalCoarseTrim,
	output logic [swr_pkg::TRIM_W-1:0]       crystalFineTrim
);

	typedef struct packed {
		swr_pkg::swr_pwr_t          state;
		logic                       inHiber;
		logic                       lfPrev;
		logic [swr_pkg::EXT_N-1:0]  extPrev;
		logic                       irqSeen;
		logic [31:0]                count;
		logic [31:0]                nextPoint;
		logic [31:0]                period;
		logic [31:0]                wakeCtrl;
		logic [31:0]                sleepCtrl;
		logic [31:0]                stealCtrl;
		logic [31:0]                trim;
		logic [7:0]                 status;
		logic                       ack;
		logic [31:0]                rdData;
		logic                       adcStart;
	} swr_core_st_t;

	localparam swr_core_st_t CORE_RST = '{
		state:     swr_pkg::PWR_RUN,
		period:    swr_pkg::RST_PERIOD,
		trim:      swr_pkg::RST_TRIM,
		status:    swr_pkg::RST_STATUS,
		default:   '0
	};

	swr_core_st_t               s_ff;
	swr_core_st_t               nxt_s;
	logic [swr_pkg::EXT_N+1:0]  rawIn;
	logic [swr_pkg::EXT_N+1:0]  syncIn;
	logic                       lfLevel;
	logic                       lfTick;
	logic                       cntHit;
	logic [swr_pkg::EXT_N-1:0]  extEvt;
	logic                       wakeTimer;
	logic                       wakeAny;
	logic                       busReq;
	logic                       wrAcc;
	logic [7:0]                 stsClr;
	logic [7:0]                 stsSet;
	logic                       stealReq;
	logic                       stealActive;

	// ------------------------------------------------------------
	// Byte-lane merge for register writes
	// ------------------------------------------------------------
	function automatic logic [31:0] swr_merge(input logic [31:0] oldVal,
		input logic [31:0] wrVal, input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] res;
		res = oldVal;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wrVal[8*b +: 8];
			end
		end
		return res & mask;
	endfunction : swr_merge

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Oscillator and wake pins are all foreign to sys_clk
	assign rawIn = {externalWakeInputs, xtalOscIn, ringOscIn};

	generate
		for (genvar i = 0; i < swr_pkg::EXT_N + 2; i++) begin : g_sync
			swr_sync3 u_sync (
				.sys_clk (sys_clk),
				.reset_n (reset_n),
				.asyncIn (rawIn[i]),
				.syncOut (syncIn[i])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Bus steal duty engine
	// ------------------------------------------------------------
	swr_steal_duty u_steal (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.stealReq    (stealReq),
		.dmaReq      (dmaReq),
		.offTime     (s_ff.stealCtrl[swr_pkg::BS_OFF +: swr_pkg::OFF_W]),
		.stealActive (stealActive)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.adcStart = 1'b0;
		stsSet = 8'h00;
		stsClr = 8'h00;
		busReq = wb_cyc_i && wb_stb_i && !s_ff.ack;
		wrAcc = wb_cyc_i && wb_stb_i && wb_we_i && s_ff.ack;

		// Slow clock edge as an enable; switching source may add or drop one tick
		lfLevel = s_ff.sleepCtrl[swr_pkg::SC_XTAL_SEL] ? syncIn[1] : syncIn[0];
		lfTick = lfLevel && !s_ff.lfPrev;
		nxt_s.lfPrev = lfLevel;
		if (lfTick) begin
			nxt_s.count = s_ff.count + 32'h0000_0001;
		end

		// Time-out on equality, re-armed in the same cycle
		cntHit = s_ff.wakeCtrl[swr_pkg::WC_CNT_EN] && (s_ff.count == s_ff.nextPoint);
		if (cntHit) begin
			nxt_s.nextPoint = s_ff.count + s_ff.period;
			stsSet[swr_pkg::ST_CNT] = 1'b1;
		end

		// External wake detection per input
		for (int i = 0; i < swr_pkg::EXT_N; i++) begin
			extEvt[i] = s_ff.wakeCtrl[swr_pkg::WC_EXT_EN + i] &&
				(s_ff.wakeCtrl[swr_pkg::WC_EXT_EDGE + i] ?
				(syncIn[i+2] && !s_ff.extPrev[i]) : syncIn[i+2]);
		end
		nxt_s.extPrev = syncIn[swr_pkg::EXT_N+1:2];
		stsSet[swr_pkg::ST_EXT +: swr_pkg::EXT_N] = extEvt;

		wakeTimer = wakeTimerExpire && s_ff.wakeCtrl[swr_pkg::WC_TIMER_EN];
		wakeAny = wakeTimer || cntHit || (|extEvt);

		// Power sequencing
		unique case (s_ff.state)
			swr_pkg::PWR_RUN: begin
				if (s_ff.sleepCtrl[swr_pkg::SC_HIBER] || s_ff.sleepCtrl[swr_pkg::SC_DOZE]) begin
					nxt_s.inHiber = s_ff.sleepCtrl[swr_pkg::SC_HIBER];
					stsSet[swr_pkg::ST_SYNC] = 1'b1;
					nxt_s.state = swr_pkg::PWR_PRE_SLEEP;
				end
			end
			swr_pkg::PWR_PRE_SLEEP: begin
				if (!s_ff.status[swr_pkg::ST_SYNC]) begin
					nxt_s.state = swr_pkg::PWR_SLEEP;
				end
			end
			swr_pkg::PWR_SLEEP: begin
				if (s_ff.inHiber && s_ff.wakeCtrl[swr_pkg::WC_AUTO_ADC] && cntHit && !wakeTimer) begin
					nxt_s.adcStart = 1'b1;
					nxt_s.state = swr_pkg::PWR_ADC;
				end else if (wakeAny) begin
					if (wakeTimer || cntHit) begin
						stsSet[swr_pkg::ST_HIBER_WK] = s_ff.inHiber;
						stsSet[swr_pkg::ST_DOZE_WAKE] = !s_ff.inHiber;
					end
					stsSet[swr_pkg::ST_SYNC] = 1'b1;
					nxt_s.state = swr_pkg::PWR_WAKE_SYNC;
				end
			end
			swr_pkg::PWR_ADC: begin
				if (adcIrq) begin
					nxt_s.state = swr_pkg::PWR_RUN;
				end else if (adcDone) begin
					nxt_s.state = swr_pkg::PWR_SLEEP;
				end
			end
			swr_pkg::PWR_WAKE_SYNC: begin
				if (!s_ff.status[swr_pkg::ST_SYNC]) begin
					nxt_s.state = swr_pkg::PWR_RUN;
				end
			end
			default: begin
				nxt_s.state = swr_pkg::PWR_RUN;
			end
		endcase

		// Request bits drop once the sequence has taken them
		if (s_ff.state == swr_pkg::PWR_RUN && nxt_s.state == swr_pkg::PWR_PRE_SLEEP) begin
			nxt_s.sleepCtrl[swr_pkg::SC_HIBER] = 1'b0;
			nxt_s.sleepCtrl[swr_pkg::SC_DOZE] = 1'b0;
		end

		// Register writes land at the edge where the master sees ack
		if (wrAcc) begin
			unique case (wb_adr_i)
				swr_pkg::ADR_WAKE_CTRL:
					nxt_s.wakeCtrl = swr_merge(s_ff.wakeCtrl, wb_dat_i, wb_sel_i,
						swr_pkg::WC_MASK);
				swr_pkg::ADR_SLEEP_CTRL:
					nxt_s.sleepCtrl = swr_merge(s_ff.sleepCtrl, wb_dat_i, wb_sel_i,
						swr_pkg::SC_MASK);
				swr_pkg::ADR_STATUS:
					stsClr = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
				swr_pkg::ADR_PERIOD: begin
					nxt_s.period = swr_merge(s_ff.period, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
					nxt_s.nextPoint = s_ff.count + nxt_s.period;
				end
				swr_pkg::ADR_STEAL: begin
					nxt_s.stealCtrl = swr_merge(s_ff.stealCtrl, wb_dat_i, wb_sel_i,
						swr_pkg::BS_MASK);
					nxt_s.irqSeen = 1'b0;
				end
				swr_pkg::ADR_TRIM:
					nxt_s.trim = swr_merge(s_ff.trim, wb_dat_i, wb_sel_i,
						swr_pkg::TR_MASK);
				default: begin
				end
			endcase
		end

		// Set beats clear so no event is lost to a racing W1C
		nxt_s.status = (s_ff.status & ~stsClr) | stsSet;

		// Wait-for-interrupt latch; a fresh interrupt beats a steal rewrite
		if (s_ff.stealCtrl[swr_pkg::BS_MODEM] && s_ff.stealCtrl[swr_pkg::BS_UNTIL_IRQ] &&
			anyIrqReq) begin
			nxt_s.irqSeen = 1'b1;
		end

		// Read path; the count is captured whole in one access
		nxt_s.ack = busReq;
		if (busReq) begin
			unique case (wb_adr_i)
				swr_pkg::ADR_WAKE_CTRL:  nxt_s.rdData = s_ff.wakeCtrl;
				swr_pkg::ADR_SLEEP_CTRL: nxt_s.rdData = s_ff.sleepCtrl;
				swr_pkg::ADR_STATUS:     nxt_s.rdData = {24'h00_0000, s_ff.status};
				swr_pkg::ADR_PERIOD:     nxt_s.rdData = s_ff.period;
				swr_pkg::ADR_COUNT:      nxt_s.rdData = s_ff.count;
				swr_pkg::ADR_STEAL:      nxt_s.rdData = s_ff.stealCtrl;
				swr_pkg::ADR_TRIM:       nxt_s.rdData = s_ff.trim;
				default:                 nxt_s.rdData = swr_pkg::RST_WORD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Trims reset only here, so a hibernate cycle keeps them
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= CORE_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------
	// Bus steal request selection
	// ------------------------------------------------------------
	assign stealReq = s_ff.stealCtrl[swr_pkg::BS_MANUAL] ||
		(s_ff.stealCtrl[swr_pkg::BS_MODEM] && s_ff.stealCtrl[swr_pkg::BS_UNTIL_IRQ] &&
		!s_ff.irqSeen) ||
		(s_ff.stealCtrl[swr_pkg::BS_MODEM] && !s_ff.stealCtrl[swr_pkg::BS_UNTIL_IRQ] &&
		modemActive);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_dat_o           = s_ff.rdData;
	assign wb_ack_o           = s_ff.ack;
	assign counterIrqReq      = s_ff.status[swr_pkg::ST_CNT] &&
		s_ff.wakeCtrl[swr_pkg::WC_CNT_IEN];
	assign extIrqReq          = |(s_ff.status[swr_pkg::ST_EXT +: swr_pkg::EXT_N] &
		s_ff.wakeCtrl[swr_pkg::WC_EXT_IEN +: swr_pkg::EXT_N]);
	assign sleepPowerDown     = s_ff.state == swr_pkg::PWR_SLEEP;
	// Doze keeps the reference running; hibernate stops it until a wake
	assign refOscEnable       = !(s_ff.state == swr_pkg::PWR_SLEEP && s_ff.inHiber);
	assign adcStart           = s_ff.adcStart;
	assign busStealActive     = stealActive;
	// Auto conversion halts the CPU from the ADC state, apart from the steal engine, but still yields to DMA
	assign cpuHalt            = stealActive ||
		(s_ff.state == swr_pkg::PWR_ADC && !dmaReq);
	assign processorRetention = s_ff.sleepCtrl[swr_pkg::SC_RETAIN];
	assign crystalCoarseTrim  = s_ff.trim[swr_pkg::TR_COARSE +: swr_pkg::TRIM_W];
	assign crystalFineTrim    = s_ff.trim[swr_pkg::TR_FINE +: swr_pkg::TRIM_W];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence swr_sleep_req_s;
		s_ff.state == swr_pkg::PWR_RUN &&
		(s_ff.sleepCtrl[swr_pkg::SC_HIBER] || s_ff.sleepCtrl[swr_pkg::SC_DOZE]);
	endsequence

	sequence swr_entry_sync_s;
		s_ff.state == swr_pkg::PWR_PRE_SLEEP && s_ff.status[swr_pkg::ST_SYNC];
	endsequence

	sequence swr_adc_enter_s;
		s_ff.state == swr_pkg::PWR_SLEEP && s_ff.inHiber &&
		s_ff.wakeCtrl[swr_pkg::WC_AUTO_ADC] && cntHit && !wakeTimer;
	endsequence

	count_tick_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		lfTick |=> s_ff.count == $past(s_ff.count) + 32'h0000_0001)
		else $error("counter missed a slow tick");

	count_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!lfTick |=> $stable(s_ff.count))
		else $error("counter moved without tick");

	timeout_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(s_ff.status[swr_pkg::ST_CNT]) |-> $past(s_ff.wakeCtrl[swr_pkg::WC_CNT_EN]))
		else $error("time-out while disabled");

	timeout_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cntHit |=> s_ff.status[swr_pkg::ST_CNT])
		else $error("time-out flag not set");

	next_point_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(cntHit && !wrAcc) |=> s_ff.nextPoint == $past(s_ff.count) + $past(s_ff.period))
		else $error("next time-out point wrong");

	irq_forward_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(cntHit && s_ff.wakeCtrl[swr_pkg::WC_CNT_IEN] && !wrAcc) |=> counterIrqReq)
		else $error("counter interrupt not raised");

	entry_sync_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		swr_sleep_req_s |=> swr_entry_sync_s)
		else $error("entry did not raise sync");

	entry_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		swr_entry_sync_s |=> s_ff.state != swr_pkg::PWR_SLEEP)
		else $error("powered down before sync cleared");

	exit_sync_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(s_ff.state == swr_pkg::PWR_WAKE_SYNC) |-> s_ff.status[swr_pkg::ST_SYNC])
		else $error("exit did not raise sync");

	wake_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_ff.state == swr_pkg::PWR_SLEEP && wakeTimer) |=>
		s_ff.status[swr_pkg::ST_HIBER_WK] || s_ff.status[swr_pkg::ST_DOZE_WAKE])
		else $error("wake flag not set");

	adc_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		swr_adc_enter_s |=> adcStart && cpuHalt == !dmaReq ##1 !adcStart)
		else $error("auto conversion start not a single pulse");

	adc_reenter_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_ff.state == swr_pkg::PWR_ADC && adcDone && !adcIrq) |=>
		s_ff.state == swr_pkg::PWR_SLEEP && !refOscEnable)
		else $error("quiet conversion did not re-enter hibernate");

	adc_unhalt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(s_ff.state == swr_pkg::PWR_ADC && adcIrq) |=>
		s_ff.state == swr_pkg::PWR_RUN && cpuHalt == stealActive)
		else $error("ADC interrupt did not release CPU");

	bus_ack_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("bus request not acknowledged");

endmodule : swr_sleep_wake

// ---- test/swr_adc_model.sv ----
// Converter partner answering each conversion start
`timescale 1ns/100ps
module swr_adc_model (
	input  wire logic sys_clk,
	input  wire logic reset_n,
	input  wire logic adcStart,
	input  wire logic irqMode,
	output logic      adcDone,
	output logic      adcIrq
);
	logic [2:0] busy_ff;
	// One sequence takes three cycles; a start during a sequence gets its own answer three cycles after it
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_ff <= 3'h0;
		end else begin
			busy_ff <= {busy_ff[1:0], adcStart};
		end
	end
	assign adcDone = busy_ff[2] & ~irqMode;
	assign adcIrq  = busy_ff[2] & irqMode;
endmodule : swr_adc_model

// ---- test/swr_sleep_wake_bench.sv ----
// Bench driving the sleep, wake and counter block over Wishbone
`timescale 1ns/100ps
module swr_sleep_wake_bench;
	logic        sys_clk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0, ringOscIn = 1'b0, oscRun = 1'b0, dmaReq = 1'b0;
	logic        wakeTimerExpire = 1'b0, irqMode = 1'b0, stealSeen, wb_ack_o;
	logic        adcDone, adcIrq, counterIrqReq, sleepPowerDown, refOscEnable, adcStart;
	logic        busStealActive, cpuHalt, processorRetention;
	logic        extIrqReq, modemActive = 1'b0, anyIrqReq = 1'b0;
	logic [3:0]  externalWakeInputs = 4'h0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, rd2;
	logic [4:0]  crystalCoarseTrim, crystalFineTrim;
	logic [15:0] tick = 16'h0;
	int          n_fail = 0, comparisons = 0, nStarts = 0;

	swr_sleep_wake uut (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ringOscIn, .xtalOscIn(1'b0),
		.externalWakeInputs, .wakeTimerExpire, .modemActive, .dmaReq,
		.anyIrqReq, .adcDone, .adcIrq, .counterIrqReq, .extIrqReq,
		.sleepPowerDown, .refOscEnable, .adcStart, .busStealActive, .cpuHalt,
		.processorRetention, .crystalCoarseTrim, .crystalFineTrim);
	swr_adc_model adc (.sys_clk, .reset_n, .adcStart, .irqMode, .adcDone, .adcIrq);

	always #50 sys_clk = ~sys_clk;
	// Slow oscillator pin runs only when asked, so counts stay still while reading
	always @(posedge sys_clk) begin
		tick <= tick + 16'h1;
		if (oscRun && tick[1:0] == 2'h0) ringOscIn <= ~ringOscIn;
		if (adcStart && cpuHalt) nStarts <= nStarts + 1;
		if (tick == 16'h0FA0) begin
			n_fail++;
			final_report();
		end
	end

	task final_report;
		if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Classic cycle: hold until ack is sampled, then idle one cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge sys_clk);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt

	// Steal is duty cycled, so look over a window rather than one edge
	task steal_seen(input int n);
		stealSeen = 1'b0;
		repeat (n) begin
			@(posedge sys_clk);
			stealSeen |= busStealActive;
		end
	endtask : steal_seen

	// Reset, trims across hibernate, sync handshakes, counter, bus steal
	initial begin
		wt(5);
		reset_n <= 1'b1;
		wt(1);
		wb(1'b0, swr_pkg::ADR_TRIM, 32'h0);
		chk("trim reset", rd, swr_pkg::RST_TRIM);
		wb(1'b1, swr_pkg::ADR_TRIM, 32'h0000_0A15);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0000_0001);
		wb(1'b1, swr_pkg::ADR_SLEEP_CTRL, 32'h0000_0005);
		wb(1'b0, swr_pkg::ADR_STATUS, 32'h0);
		chk("entry sync", rd, 32'h0000_0001);
		chk("held awake", sleepPowerDown, 32'h0);
		wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0001);
		wt(2);
		chk("asleep", sleepPowerDown, 32'h1);
		chk("ref osc off", refOscEnable, 32'h0);
		wakeTimerExpire <= 1'b1;
		wt(1);
		wakeTimerExpire <= 1'b0;
		wt(2);
		wb(1'b0, swr_pkg::ADR_STATUS, 32'h0);
		chk("wake status", rd, 32'h0000_0003);
		chk("coarse kept", crystalCoarseTrim, 32'h15);
		chk("fine kept", crystalFineTrim, 32'h0A);
		wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0003);
		wb(1'b1, swr_pkg::ADR_PERIOD, 32'h0000_0003);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0001_0002);
		oscRun <= 1'b1;
		wt(80);
		oscRun <= 1'b0;
		wt(10);
		wb(1'b0, swr_pkg::ADR_STATUS, 32'h0);
		chk("timeout flag", rd, 32'h0000_0008);
		chk("timeout irq", counterIrqReq, 32'h1);
		wb(1'b0, swr_pkg::ADR_COUNT, 32'h0);
		rd2 = rd;
		wb(1'b0, swr_pkg::ADR_COUNT, 32'h0);
		chk("count stable", rd, rd2);
		chk("count moved", rd > 32'h3, 32'h1);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0000_0002);
		chk("irq masked", counterIrqReq, 32'h0);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0);
		wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0008);
		oscRun <= 1'b1;
		wt(80);
		oscRun <= 1'b0;
		wb(1'b0, swr_pkg::ADR_STATUS, 32'h0);
		chk("no timeout", rd, 32'h0);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0011_1100);
		externalWakeInputs <= 4'h1;
		wt(6);
		chk("ext irq", extIrqReq, 32'h1);
		wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0010);
		wb(1'b0, swr_pkg::ADR_STATUS, 32'h0);
		chk("ext edge once", rd, 32'h0);
		externalWakeInputs <= 4'h0;
		wb(1'b1, swr_pkg::ADR_STEAL, 32'h0000_0302);
		steal_seen(6);
		chk("manual steal", stealSeen, 32'h1);
		dmaReq <= 1'b1;
		wt(2);
		chk("dma first", busStealActive, 32'h0);
		chk("cpu runs", cpuHalt, 32'h0);
		dmaReq <= 1'b0;
		wb(1'b1, swr_pkg::ADR_STEAL, 32'h0000_0301);
		steal_seen(6);
		chk("modem idle", stealSeen, 32'h0);
		modemActive <= 1'b1;
		steal_seen(6);
		chk("modem steal", stealSeen, 32'h1);
		modemActive <= 1'b0;
		wb(1'b1, swr_pkg::ADR_STEAL, 32'h0000_0305);
		steal_seen(6);
		chk("wait steal", stealSeen, 32'h1);
		anyIrqReq <= 1'b1;
		wt(1);
		anyIrqReq <= 1'b0;
		steal_seen(6);
		chk("irq releases", stealSeen, 32'h0);
		wb(1'b1, swr_pkg::ADR_STEAL, 32'h0);
		wt(5);
		chk("steal off", busStealActive, 32'h0);
		// Auto conversion: a quiet pass sleeps again, an interrupting one wakes
		wb(1'b1, swr_pkg::ADR_PERIOD, 32'h0000_0004);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0000_000A);
		wb(1'b1, swr_pkg::ADR_SLEEP_CTRL, 32'h0000_0005);
		wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0001);
		oscRun <= 1'b1;
		wt(40);
		oscRun <= 1'b0;
		wt(10);
		chk("adc once", nStarts, 32'h1);
		chk("back asleep", sleepPowerDown, 32'h1);
		irqMode <= 1'b1;
		oscRun <= 1'b1;
		wt(40);
		oscRun <= 1'b0;
		wt(10);
		chk("adc again", nStarts, 32'h2);
		chk("cpu released", cpuHalt, 32'h0);
		chk("awake", sleepPowerDown, 32'h0);
		wb(1'b1, swr_pkg::ADR_WAKE_CTRL, 32'h0);
		chk("retention", processorRetention, 32'h1);
		final_report();
	end
endmodule : swr_sleep_wake_bench
